/* File: sbs_defs.svh */
`ifndef SBS_DEFS_SVH
`define SBS_DEFS_SVH

// Default geometry of the storage core.
`define SBS_ADDR_W 8
`define SBS_LANES 4
`define SBS_LANE_W 9

// Width of the burst counter on the low address bits.
`define SBS_BURST_W 2

// Sleep entry and wake-up delays, in clock cycles.
`define SBS_SLEEP_ENTRY_CYC 2'd2
`define SBS_WAKE_CYC 2'd2

// Values the synchronised pin inputs take until the pins have been sampled.
`define SBS_RST_SLEEP 1'b0
`define SBS_RST_BYPASS_N 1'b1
`define SBS_RST_LINEAR_N 1'b0
`define SBS_SYNC_RST {`SBS_RST_LINEAR_N, `SBS_RST_BYPASS_N, `SBS_RST_SLEEP}

// Bit positions inside the synchroniser vector.
`define SBS_SYNC_SLEEP 0
`define SBS_SYNC_BYPASS_N 1
`define SBS_SYNC_LINEAR_N 2
`define SBS_SYNC_N 3

`endif

/* File: sbs_pkg.sv */
package sbs_pkg;

   typedef enum logic [3:0] {
      SBS_AWAKE = 4'h1,
      SBS_ENTERING = 4'h2,
      SBS_ASLEEP = 4'h4,
      SBS_WAKING = 4'h8
   } sbs_sleep_state_t;

   typedef enum logic [2:0] {
      SBS_BURST_NONE = 3'h1,
      SBS_BURST_READ = 3'h2,
      SBS_BURST_WRITE = 3'h4
   } sbs_burst_kind_t;

endpackage

/* File: sbs_burst_if.sv */
`timescale 1ns/1ps
interface sbs_burst_if;
   logic load;
   logic step;
   logic interleave;
   logic [1:0] start;
   logic [1:0] low;

   modport ctrl (output load, output step, output interleave, output start, input low);
   modport cnt (input load, input step, input interleave, input start, output low);
endinterface

/* File: sbs_burst_counter.sv */
`timescale 1ns/1ps
`include "sbs_defs.svh"
module sbs_burst_counter
   import sbs_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   sbs_burst_if.cnt bus
);

   logic [1:0] start_q;
   logic [1:0] count_q;
   logic [1:0] next_count_w;

   // The low bits shown are those of the access made on the next step.
   assign next_count_w = count_q + 2'h1;
   assign bus.low = bus.interleave ? (start_q ^ next_count_w)
                                   : (start_q + next_count_w);

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         start_q <= 2'h0;
         count_q <= 2'h0;
      end
      else if (bus.load)
      begin
         start_q <= bus.start;
         count_q <= 2'h0;
      end
      else if (bus.step)
      begin
         count_q <= next_count_w;
      end
   end

   AST_WRAP_FIFTH: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      bus.load ##1 (bus.step && !bus.load) [*3] ##1 (bus.step && !bus.load)
         |-> bus.low == start_q)
      else $error("burst counter did not wrap to its start on the fifth access");

   AST_LINEAR_SECOND: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      bus.load && !bus.interleave ##1 bus.step && !bus.load && !bus.interleave
         |-> bus.low == $past(bus.start) + 2'h1)
      else $error("linear burst second address wrong");

endmodule // sbs_burst_counter

/* File: sbs_sram_control.sv */
`timescale 1ns/1ps
`include "sbs_defs.svh"
module sbs_sram_control
   import sbs_pkg::*;
#(
   parameter int ADDR_W = `SBS_ADDR_W,
   parameter int LANES = `SBS_LANES,
   parameter int LANE_W = `SBS_LANE_W
)
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic clk_en_n_i,
   input wire logic advance_load_i,
   input wire logic write_n_i,
   input wire logic [LANES-1:0] byte_lane_strobes_n_i,
   input wire logic chip_select_first_n_i,
   input wire logic chip_select_second_i,
   input wire logic chip_select_third_n_i,
   input wire logic out_enable_n_i,
   input wire logic sleep_request_i,
   input wire logic output_register_bypass_n_i,
   input wire logic linear_order_n_i,
   input wire logic [LANES*LANE_W-1:0] dq_i,
   output logic [LANES*LANE_W-1:0] dq_o,
   output logic dq_oe_o,
   output logic asleep_o,
   output logic deselected_o
);

   localparam int DATA_W = LANES * LANE_W;
   localparam int DEPTH = 2 ** ADDR_W;
   localparam logic [`SBS_SYNC_N-1:0] SYNC_RST = `SBS_SYNC_RST;

   generate
      if (ADDR_W < `SBS_BURST_W || LANES < 1 || LANE_W < 1)
      begin : g_bad_params
         $error("sbs_sram_control: unsupported geometry");
      end
   endgenerate

   // Pin inputs from outside the clock domain.
   logic [`SBS_SYNC_N-1:0] raw_w;
   logic [`SBS_SYNC_N-1:0] meta_q;
   logic [`SBS_SYNC_N-1:0] mid_q;
   logic [`SBS_SYNC_N-1:0] last_q;
   logic [`SBS_SYNC_N-1:0] agreed_q;
   logic flow_w;
   logic interleave_w;
   logic sleep_lvl_w;

   // Sleep control.
   sbs_sleep_state_t state_q;
   sbs_sleep_state_t state_d;
   logic [1:0] slp_cnt_q;
   logic [1:0] slp_cnt_d;
   logic ignore_w;

   // Command decode.
   logic take_w;
   logic selected_w;
   logic load_w;
   logic any_lane_w;
   logic begin_read_w;
   logic begin_write_w;
   logic begin_abort_w;
   logic deselect_w;
   logic cont_w;
   logic rd_now_w;
   logic wr_now_w;
   logic [ADDR_W-1:0] acc_addr_w;
   sbs_burst_kind_t kind_q;
   logic [ADDR_W-1:0] base_q;
   logic deselected_q;

   // Data path.
   logic [DATA_W-1:0] mem_q [DEPTH];
   logic [DATA_W-1:0] rd_data_w;
   logic [DATA_W-1:0] pipe_data_q;
   logic pipe_valid_q;
   logic [DATA_W-1:0] dq_q;
   logic drive_q;
   logic w1_valid_q;
   logic [ADDR_W-1:0] w1_addr_q;
   logic [LANES-1:0] w1_lanes_n_q;
   logic w2_valid_q;
   logic [ADDR_W-1:0] w2_addr_q;
   logic [LANES-1:0] w2_lanes_n_q;
   logic wr_fire_w;
   logic [ADDR_W-1:0] wr_addr_w;
   logic [LANES-1:0] wr_lanes_n_w;

   sbs_burst_if burst ();

   sbs_burst_counter u_burst (
      .clk_i (clk_i),
      .resetn_i (resetn_i),
      .bus (burst.cnt)
   );

   // A change counts once the second and third stages agree.
   assign raw_w = {linear_order_n_i, output_register_bypass_n_i, sleep_request_i};

   generate
      for (genvar i = 0; i < `SBS_SYNC_N; i++)
      begin : g_sync
         always_ff @(posedge clk_i)
         begin
            if (!resetn_i)
            begin
               meta_q[i] <= SYNC_RST[i];
               mid_q[i] <= SYNC_RST[i];
               last_q[i] <= SYNC_RST[i];
               agreed_q[i] <= SYNC_RST[i];
            end
            else
            begin
               meta_q[i] <= raw_w[i];
               mid_q[i] <= meta_q[i];
               last_q[i] <= mid_q[i];
               if (mid_q[i] == last_q[i])
               begin
                  agreed_q[i] <= last_q[i];
               end
            end
         end
      end
   endgenerate

   assign flow_w = !agreed_q[`SBS_SYNC_BYPASS_N];
   assign interleave_w = agreed_q[`SBS_SYNC_LINEAR_N];
   assign sleep_lvl_w = agreed_q[`SBS_SYNC_SLEEP];

   // Sleep sequencing; the waking cycles still ignore commands.
   always_comb
   begin
      state_d = state_q;
      slp_cnt_d = slp_cnt_q + 2'h1;
      unique case (state_q)
         SBS_AWAKE:
         begin
            slp_cnt_d = 2'h0;
            if (sleep_lvl_w)
            begin
               state_d = SBS_ENTERING;
            end
         end
         SBS_ENTERING:
         begin
            if (!sleep_lvl_w)
            begin
               state_d = SBS_AWAKE;
            end
            else if (slp_cnt_q == `SBS_SLEEP_ENTRY_CYC - 2'h1)
            begin
               state_d = SBS_ASLEEP;
            end
         end
         SBS_ASLEEP:
         begin
            slp_cnt_d = 2'h0;
            if (!sleep_lvl_w)
            begin
               state_d = SBS_WAKING;
            end
         end
         SBS_WAKING:
         begin
            if (sleep_lvl_w)
            begin
               state_d = SBS_ASLEEP;
            end
            else if (slp_cnt_q == `SBS_WAKE_CYC - 2'h1)
            begin
               state_d = SBS_AWAKE;
            end
         end
         default:
         begin
            state_d = SBS_AWAKE;
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         state_q <= SBS_AWAKE;
         slp_cnt_q <= 2'h0;
      end
      else
      begin
         state_q <= state_d;
         slp_cnt_q <= slp_cnt_d;
      end
   end

   assign ignore_w = state_q == SBS_ASLEEP || state_q == SBS_WAKING;

   // Clock enable high freezes every pipeline stage; sleep freezes them too but clears the output drive.
   assign take_w = !clk_en_n_i && !ignore_w;
   assign selected_w = !chip_select_first_n_i && chip_select_second_i
                       && !chip_select_third_n_i;
   assign load_w = !advance_load_i;
   assign any_lane_w = !(&byte_lane_strobes_n_i);
   assign begin_read_w = take_w && load_w && selected_w && write_n_i;
   assign begin_write_w = take_w && load_w && selected_w && !write_n_i
                          && any_lane_w;
   assign begin_abort_w = take_w && load_w && selected_w && !write_n_i
                          && !any_lane_w;
   assign deselect_w = take_w && load_w && !selected_w;
   assign cont_w = take_w && advance_load_i && kind_q != SBS_BURST_NONE;
   assign rd_now_w = begin_read_w || (cont_w && kind_q == SBS_BURST_READ);
   assign wr_now_w = begin_write_w
                     || (cont_w && kind_q == SBS_BURST_WRITE && any_lane_w);
   assign acc_addr_w = load_w ? addr_i : {base_q[ADDR_W-1:`SBS_BURST_W], burst.low};

   assign burst.load = begin_read_w || begin_write_w;
   assign burst.step = cont_w;
   assign burst.start = addr_i[1:0];
   assign burst.interleave = interleave_w;

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         kind_q <= SBS_BURST_NONE;
         base_q <= '0;
         deselected_q <= 1'b1;
      end
      else if (take_w && load_w)
      begin
         base_q <= addr_i;
         kind_q <= begin_read_w ? SBS_BURST_READ
                 : begin_write_w ? SBS_BURST_WRITE : SBS_BURST_NONE;
         deselected_q <= deselect_w;
      end
   end

   // Write data arrives one edge late in flow-through, two in pipeline.
   assign rd_data_w = mem_q[acc_addr_w];
   assign wr_fire_w = take_w && (flow_w ? w1_valid_q : w2_valid_q);
   assign wr_addr_w = flow_w ? w1_addr_q : w2_addr_q;
   assign wr_lanes_n_w = flow_w ? w1_lanes_n_q : w2_lanes_n_q;

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         w1_valid_q <= 1'b0;
         w2_valid_q <= 1'b0;
         w1_addr_q <= '0;
         w2_addr_q <= '0;
         w1_lanes_n_q <= '1;
         w2_lanes_n_q <= '1;
      end
      else if (take_w)
      begin
         w1_valid_q <= wr_now_w;
         w1_addr_q <= acc_addr_w;
         w1_lanes_n_q <= byte_lane_strobes_n_i;
         w2_valid_q <= w1_valid_q;
         w2_addr_q <= w1_addr_q;
         w2_lanes_n_q <= w1_lanes_n_q;
      end
   end

   always_ff @(posedge clk_i)
   begin
      for (int l = 0; l < LANES; l++)
      begin
         if (wr_fire_w && !wr_lanes_n_w[l])
         begin
            mem_q[wr_addr_w][l*LANE_W +: LANE_W] <= dq_i[l*LANE_W +: LANE_W];
         end
      end
   end

   // Drive follows reads only, so write cycles leave the bus floated.
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         drive_q <= 1'b0;
         pipe_valid_q <= 1'b0;
         pipe_data_q <= '0;
         dq_q <= '0;
      end
      else if (ignore_w)
      begin
         drive_q <= 1'b0;
      end
      else if (take_w)
      begin
         pipe_valid_q <= rd_now_w;
         pipe_data_q <= rd_data_w;
         dq_q <= flow_w ? rd_data_w : pipe_data_q;
         drive_q <= flow_w ? rd_now_w : pipe_valid_q;
      end
   end

   assign dq_o = dq_q;
   assign dq_oe_o = drive_q && !out_enable_n_i;
   assign asleep_o = state_q[2];
   assign deselected_o = deselected_q;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   AST_READ_FLOW: assert property (
      begin_read_w && flow_w |=> drive_q)
      else $error("flow-through read did not drive on the next cycle");

   AST_READ_PIPE: assert property (
      begin_read_w && !flow_w ##1 take_w |=> drive_q && dq_q == $past(pipe_data_q))
      else $error("pipelined read data not presented through output register");

   AST_WRITE_FLOATS: assert property (
      wr_now_w && flow_w && !rd_now_w |=> !drive_q)
      else $error("bus driven in the cycle after a write command");

   AST_ABORT_NOP: assert property (
      begin_abort_w |=> !w1_valid_q)
      else $error("write abort queued a write");

   AST_DESELECT: assert property (
      deselect_w |=> deselected_q && kind_q == SBS_BURST_NONE)
      else $error("deselect did not end the burst");

   AST_STALL_HOLD: assert property (
      clk_en_n_i && !ignore_w |=> $stable(dq_q) && $stable(drive_q) && $stable(kind_q))
      else $error("stall edge changed state");

   AST_SLEEP_ENTRY: assert property (
      state_q == SBS_AWAKE && sleep_lvl_w ##1 sleep_lvl_w [*2] |=> state_q == SBS_ASLEEP)
      else $error("sleep not entered two cycles after request");

   AST_WAKE: assert property (
      state_q == SBS_ASLEEP && !sleep_lvl_w ##1 !sleep_lvl_w [*2] |=> state_q == SBS_AWAKE)
      else $error("wake-up did not take two cycles");

   AST_SLEEP_HIZ: assert property (
      $past(ignore_w) && ignore_w |-> !dq_oe_o && !wr_fire_w)
      else $error("outputs driven or write made while asleep");

   AST_WRITE_PIPE: assert property (
      begin_write_w && !flow_w ##1 take_w && !flow_w ##1 take_w && !flow_w |-> wr_fire_w)
      else $error("pipelined write data not taken at the third edge");

   AST_WRITE_FLOW: assert property (
      begin_write_w && flow_w ##1 take_w && flow_w |-> wr_fire_w)
      else $error("flow-through write data not taken at the second edge");

   AST_OE_ASYNC: assert property (
      out_enable_n_i |-> !dq_oe_o)
      else $error("data pins driven with output enable high");

   COV_BURST_READ: cover property (begin_read_w ##1 cont_w [*3]);
   COV_PIPE_WRITE: cover property (begin_write_w && !flow_w ##1 take_w ##1 wr_fire_w);
   COV_SLEEP: cover property (state_q == SBS_ENTERING ##1 state_q == SBS_ASLEEP);
   COV_STALL_READ: cover property (drive_q && clk_en_n_i ##1 drive_q);

endmodule // sbs_sram_control

/* File: sbs_mem_ctl_model.sv */
`timescale 1ns/1ps
module sbs_mem_ctl_model
(
   input wire logic clk_i,
   output logic [7:0] addr_o,
   output logic clk_en_n_o,
   output logic advance_load_o,
   output logic write_n_o,
   output logic [3:0] byte_lane_strobes_n_o,
   output logic chip_select_first_n_o,
   output logic chip_select_second_o,
   output logic chip_select_third_n_o,
   output logic out_enable_n_o,
   output logic [35:0] wdata_o
);
   logic loaded_q;

   initial
   begin
      {addr_o, clk_en_n_o, advance_load_o, write_n_o} = {8'h00, 3'b101};
      {chip_select_first_n_o, chip_select_second_o, chip_select_third_n_o} = 3'b110;
      byte_lane_strobes_n_o = 4'hf;
      out_enable_n_o = 1'b0;
      wdata_o = 36'h0;
      loaded_q = 1'b0;
   end

   // Issues one command just after a rising edge; it stands until the next call.
   task automatic drive(input logic cke_n, input logic advance_load, input logic wn,
      input logic [3:0] be_n, input logic [2:0] cs, input logic [7:0] a,
      input logic [35:0] d, input logic dv, input logic oe_n);
      logic cont;
      cont = advance_load & loaded_q;
      @(posedge clk_i);
      loaded_q <= loaded_q | ~advance_load;
      clk_en_n_o <= cke_n;
      advance_load_o <= cont;
      write_n_o <= wn;
      byte_lane_strobes_n_o <= be_n;
      {chip_select_first_n_o, chip_select_second_o, chip_select_third_n_o} <= advance_load & !cont
         ? 3'b110 : cs;
      addr_o <= a;
      out_enable_n_o <= oe_n;
      // Unused data cycles show the inverse of the last value, so back-to-back ones alternate.
      wdata_o <= dv ? d : ~wdata_o;
   endtask
endmodule // sbs_mem_ctl_model

/* File: sbs_sram_control_tb.sv */
`timescale 1ns/1ps
module sbs_sram_control_tb;
   logic clk_i = 1'b0;
   logic resetn_i, sleep_request_i, bypass_n, linear_n;
   logic [7:0] addr;
   logic cke_n, advance_load, wn, cs1_n, cs2, cs3_n, oe_n;
   logic [3:0] be_n;
   logic [35:0] wdata, dq_o;
   logic dq_oe_o, asleep_o, deselected_o;
   logic [35:0] mem_exp [256];
   int errors = 0;
   int checked = 0;

   always #5 clk_i = ~clk_i;

   sbs_mem_ctl_model u_ctl (.clk_i(clk_i), .addr_o(addr), .clk_en_n_o(cke_n),
      .advance_load_o(advance_load), .write_n_o(wn), .byte_lane_strobes_n_o(be_n),
      .chip_select_first_n_o(cs1_n), .chip_select_second_o(cs2),
      .chip_select_third_n_o(cs3_n), .out_enable_n_o(oe_n), .wdata_o(wdata));

   sbs_sram_control u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr),
      .clk_en_n_i(cke_n), .advance_load_i(advance_load), .write_n_i(wn), .byte_lane_strobes_n_i(be_n),
      .chip_select_first_n_i(cs1_n), .chip_select_second_i(cs2), .chip_select_third_n_i(cs3_n),
      .out_enable_n_i(oe_n), .sleep_request_i(sleep_request_i),
      .output_register_bypass_n_i(bypass_n), .linear_order_n_i(linear_n), .dq_i(wdata),
      .dq_o(dq_o), .dq_oe_o(dq_oe_o), .asleep_o(asleep_o), .deselected_o(deselected_o));

   task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      $display("Comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic t_reset;
      #1;
      chk("reset drive", dq_oe_o, 1'b0);
      chk("reset data", dq_o, 36'h0);
      chk("reset sleep", asleep_o, 1'b0);
      chk("reset deselect", deselected_o, 1'b1);
      // Let the strap synchronisers settle on the pin values before any command.
      repeat (5) @(posedge clk_i);
      $display("Test reset done");
   endtask

   // Burst of n beats from a, then idle deselects; a stall is put before iteration stk.
   task automatic burst(input logic wr, input logic [7:0] a, input int n,
      input logic [3:0] lanes_n, input logic [7:0] salt, input logic oe, input int stk,
      input logic [2:0] cs_idle);
      int lat;
      logic [7:0] ba;
      logic [35:0] d;
      lat = bypass_n ? 2 : 1;
      for (int k = 0; k < n + lat; k++)
      begin
         ba = {a[7:2], linear_n ? a[1:0] ^ 2'(k - lat) : a[1:0] + 2'(k - lat)};
         d = {salt[3:0], ba, salt, ba, salt};
         for (int s = 0; s < ((k == stk) ? 2 : 1); s++)
         begin
            u_ctl.drive(k == stk && s == 0, k > 0 && k < n, ~wr, lanes_n,
               (k < n) ? 3'b010 : cs_idle, a, d, wr && k >= lat, oe);
            #1;
            if (k >= lat && wr)
            begin
               chk("write drive", dq_oe_o, 1'b0);
               for (int l = 0; l < 4; l++)
                  if (!lanes_n[l] && s == 0)
                     mem_exp[ba][l*9 +: 9] = d[l*9 +: 9];
            end
            else if (k >= lat)
            begin
               chk("read drive", dq_oe_o, !oe);
               if (!oe)
                  chk($sformatf("read data %h", ba), dq_o, mem_exp[ba]);
            end
         end
      end
   endtask

   task automatic t_desel;
      logic [2:0] cs_tab [3] = '{3'b110, 3'b000, 3'b011};
      foreach (cs_tab[i])
      begin
         burst(0, 8'h10, 1, 4'hf, 8'h00, 0, -1, cs_tab[i]);
         u_ctl.drive(0, 0, 1, 4'hf, cs_tab[i], 8'h10, 36'h0, 0, 0);
         #1;
         chk("deselect drive", dq_oe_o, 1'b0);
         chk("deselect flag", deselected_o, 1'b1);
      end
      repeat (2)
         u_ctl.drive(0, 1, 1, 4'hf, 3'b010, 8'h10, 36'h0, 0, 0);
      #1;
      chk("deselect continue", dq_oe_o, 1'b0);
      chk("deselect continue flag", deselected_o, 1'b1);
      $display("Test deselect done");
   endtask

   task automatic t_sleep;
      int c;
      // Raised only once every burst has finished.
      @(posedge clk_i);
      sleep_request_i <= 1'b1;
      c = 0;
      while (asleep_o !== 1'b1 && c < 20)
      begin
         @(posedge clk_i);
         #1;
         c++;
      end
      chk("sleep entry time", 36'(c >= 6 && c <= 7), 36'h1);
      u_ctl.drive(0, 0, 0, 4'h0, 3'b010, 8'h10, 36'h0, 1, 0);
      repeat (3)
         u_ctl.drive(0, 0, 1, 4'hf, 3'b110, 8'h10, 36'h0, 1, 0);
      #1;
      chk("asleep drive", dq_oe_o, 1'b0);
      @(posedge clk_i);
      sleep_request_i <= 1'b0;
      c = 0;
      while (asleep_o !== 1'b0 && c < 20)
      begin
         u_ctl.drive(0, 0, 1, 4'hf, 3'b110, 8'h10, 36'h0, 0, 0);
         #1;
         c++;
      end
      chk("wake flag", asleep_o, 1'b0);
      repeat (4)
         u_ctl.drive(0, 0, 1, 4'hf, 3'b110, 8'h10, 36'h0, 0, 0);
      burst(0, 8'h10, 1, 4'hf, 8'h00, 0, -1, 3'b110);
      $display("Test sleep done");
   endtask

   initial
   begin
      resetn_i = 1'b0;
      sleep_request_i = 1'b0;
      bypass_n = 1'b1;
      linear_n = 1'b0;
      repeat (12) @(posedge clk_i);
      resetn_i <= 1'b1;
      t_reset();
      burst(1, 8'h10, 4, 4'h0, 8'ha5, 0, -1, 3'b110);
      burst(0, 8'h11, 5, 4'hf, 8'h00, 0, 2, 3'b110);
      $display("Test pipeline linear done");
      burst(1, 8'h12, 2, 4'b1010, 8'h3c, 0, -1, 3'b110);
      burst(1, 8'h13, 1, 4'hf, 8'hc3, 0, -1, 3'b110);
      burst(0, 8'h12, 2, 4'hf, 8'h00, 0, -1, 3'b110);
      burst(0, 8'h12, 2, 4'hf, 8'h00, 1, -1, 3'b110);
      $display("Test lanes done");
      t_desel();
      @(posedge clk_i);
      resetn_i <= 1'b0;
      bypass_n <= 1'b0;
      linear_n <= 1'b1;
      repeat (12) @(posedge clk_i);
      resetn_i <= 1'b1;
      t_reset();
      burst(0, 8'h12, 4, 4'hf, 8'h00, 0, -1, 3'b110);
      burst(1, 8'h20, 4, 4'h0, 8'h96, 0, 2, 3'b110);
      burst(0, 8'h21, 5, 4'hf, 8'h00, 0, 3, 3'b110);
      $display("Test flow interleaved done");
      t_sleep();
      tally_and_finish();
   end

   initial
   begin
      repeat (5000) @(posedge clk_i);
      errors++;
      tally_and_finish();
   end
endmodule // sbs_sram_control_tb
